// ==== hw/led_output_pkg.sv ====
// Constants shared by the flash LED control register bank
package led_output_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h63;
    localparam int unsigned SCL_MAX_KHZ = 400;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] ADDR_FEAT = 8'h08;
    localparam logic [7:0] ADDR_LEVEL = 8'h09;
    localparam logic [7:0] ADDR_ENABLE = 8'h0A;
    localparam logic [7:0] ADDR_FLAGS = 8'h0B;
    localparam logic [7:0] RST_DEFAULT = 8'h03;
    localparam logic [7:0] FEAT_DEFAULT = 8'h02;
    localparam logic [7:0] LEVEL_DEFAULT = 8'h0F;
    localparam logic [7:0] ENABLE_DEFAULT = 8'h70;
    localparam logic [7:0] FLAGS_DEFAULT = 8'h00;
    localparam logic [7:0] RST_RW_MASK = 8'h03;
    localparam logic [7:0] FLAGS_MASK = 8'h2F;
    localparam int unsigned RST_BIT = 7;
    localparam int unsigned FTO_LSB = 0;
    localparam int unsigned LVP_LSB = 4;
    localparam int unsigned FLASH_LSB = 0;
    localparam int unsigned TORCH_LSB = 5;
    localparam int unsigned EN_DRV_BIT = 0;
    localparam int unsigned EN_SEL_BIT = 1;
    localparam int unsigned EN_SREG_BIT = 2;
    localparam int unsigned EN_CS_BIT = 4;
    localparam int unsigned EN_STB_BIT = 5;
    localparam int unsigned EN_TX_BIT = 6;
    localparam int unsigned EN_INPUT_VOLTAGE_MONITOR_BIT = 7;
    localparam int unsigned FL_TO_BIT = 0;
    localparam int unsigned FL_OTP_BIT = 1;
    localparam int unsigned FL_SHORT_BIT = 2;
    localparam int unsigned FL_OVP_BIT = 3;
    localparam int unsigned FL_INPUT_VOLTAGE_MONITOR_BIT = 5;
    localparam logic [3:0] LVP_TOP_CODE = 4'h8;
    localparam logic [4:0] FLASH_TOP_CODE = 5'h0F;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned FTO_STEP_MS = 100;
    localparam int unsigned FTO_STEP_CYC = FTO_STEP_MS * (CLK_HZ / 1000);
    typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_PTR, ST_WR, ST_RD} led_output_i2c_e;
endpackage : led_output_pkg

// ==== hw/led_output_sync.sv ====
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module led_output_sync #(
    parameter int unsigned W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_ff <= '0;
            o_q <= '0;
        end
        else
        begin
            meta_ff <= i_d;
            o_q <= meta_ff;
        end
    end
endmodule : led_output_sync

// ==== hw/led_output_i2c_regs.sv ====
// I2C slave register bank and flash timing of the flash LED driver
// What this block does
// - Answers as I2C slave at seven-bit address 1100011 only.
// - Serial interface works at fast-mode rates up to 400 kb/s.
// - Writing one to bit 7 of register 0x00 restores all register defaults.
// - Timeout code 000..111 selects 100 ms..800 ms flash limit.
// - Battery threshold codes 0000..0111 select 3.0 V..3.7 V.
// - Battery threshold codes 1000..1111 all select 3.8 V.
// - Torch code bits 7:5 of 0x09 select torch current.
// - Flash code bits 4:0 of 0x09 select current; 01111 and above saturate.
// - Enable bit 4 gates the LED current source; default enabled.
// - Short flag sets on short detect, clears on read.
// - Overvoltage flag bit 3 sets on trip, clears on read.
`timescale 1ns/1ns
module led_output_i2c_regs
    import led_output_pkg::*;
#(
    parameter int unsigned P_FTO_STEP_CYC = FTO_STEP_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic i_strobe,
    input wire logic i_tx_mask,
    input wire logic i_short_det,
    input wire logic i_ovp_det,
    input wire logic i_input_voltage_monitor_det,
    input wire logic i_otp_det,
    output logic o_led_enable,
    output logic o_flash_on,
    output logic o_torch_on,
    output logic [4:0] o_flash_level,
    output logic [2:0] o_torch_level,
    output logic [2:0] o_timeout_code,
    output logic [3:0] o_batt_threshold,
    output logic o_input_voltage_monitor_enable
);
    logic rst_meta_ff, rst_n;
    logic scl_s, sda_s, strobe_s, tx_s, short_s, ovp_s, input_voltage_monitor_s, otp_s;
    logic scl_n_s, sda_n_s;
    logic scl_d_ff, sda_d_ff;
    logic start, stop, rise, fall;
    led_output_i2c_e state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff, ptr_ff, rd_data;
    logic rw_ff, mack_ff, wr_stb, rd_stb, srst_ff;
    logic [7:0] rst_reg_ff, feat_ff, level_ff, enable_ff, flags_ff, flag_set;
    logic [31:0] step_cnt_ff;
    logic [2:0] steps_ff;
    logic expired_ff, trig, to_ev, flash_nxt, torch_nxt;

    // Reset release through two flops
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n <= rst_meta_ff;
        end
    end

    // Pins sampled ahead of the slave; oversampling covers 400 kb/s
    led_output_sync #(.W(8)) u_sync (
        .i_clk(i_mclk),
        .i_rst_n(rst_n),
        .i_d({~i_scl, ~i_sda, i_strobe, i_tx_mask, i_short_det, i_ovp_det, i_input_voltage_monitor_det, i_otp_det}),
        .o_q({scl_n_s, sda_n_s, strobe_s, tx_s, short_s, ovp_s, input_voltage_monitor_s, otp_s})
    );

    // Bus pins pass inverted so the synchroniser's reset value matches an idle bus
    assign scl_s = ~scl_n_s;
    assign sda_s = ~sda_n_s;

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    assign start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    assign rise = scl_s & ~scl_d_ff;
    assign fall = ~scl_s & scl_d_ff;
    assign wr_stb = fall && bit_cnt_ff == 4'h7 && state_ff == ST_WR;
    assign rd_stb = fall && bit_cnt_ff == 4'h8 && ((state_ff == ST_DEV && rw_ff) || (state_ff == ST_RD && mack_ff));

    always_comb
    begin
        unique case (ptr_ff)
            ADDR_RESET: rd_data = rst_reg_ff & RST_RW_MASK;
            ADDR_FEAT: rd_data = feat_ff;
            ADDR_LEVEL: rd_data = level_ff;
            ADDR_ENABLE: rd_data = enable_ff;
            ADDR_FLAGS: rd_data = flags_ff;
            default: rd_data = 8'h00;
        endcase
    end

    // Serial slave: sample on SCL rise, drive SDA after SCL fall
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff <= 8'h00;
            rw_ff <= 1'b0;
            mack_ff <= 1'b0;
            o_sda_oe <= 1'b0;
        end
        else if (start)
        begin
            state_ff <= ST_DEV;
            // The clock fall that closes the start is no data bit; it wraps the count to zero
            bit_cnt_ff <= 4'hF;
            o_sda_oe <= 1'b0;
        end
        else if (stop)
        begin
            state_ff <= ST_IDLE;
            o_sda_oe <= 1'b0;
        end
        else if (state_ff != ST_IDLE)
        begin
            if (rise && bit_cnt_ff < 4'h8 && state_ff != ST_RD)
                shift_ff <= {shift_ff[6:0], sda_s};
            if (rise && bit_cnt_ff == 4'h8 && state_ff == ST_RD)
                mack_ff <= ~sda_s;
            if (fall && bit_cnt_ff == 4'h7)
            begin
                bit_cnt_ff <= 4'h8;
                unique case (state_ff)
                    ST_DEV:
                    begin
                        if (shift_ff[7:1] == DEV_ADDR)
                        begin
                            o_sda_oe <= 1'b1;
                            rw_ff <= shift_ff[0];
                        end
                        else
                            state_ff <= ST_IDLE;
                    end
                    ST_PTR:
                    begin
                        ptr_ff <= shift_ff;
                        o_sda_oe <= 1'b1;
                    end
                    ST_WR: o_sda_oe <= 1'b1;
                    ST_RD: o_sda_oe <= 1'b0;
                    ST_IDLE: ;
                endcase
            end
            else if (fall && bit_cnt_ff == 4'h8)
            begin
                bit_cnt_ff <= 4'h0;
                o_sda_oe <= 1'b0;
                if (rd_stb)
                begin
                    state_ff <= ST_RD;
                    shift_ff <= rd_data;
                    o_sda_oe <= ~rd_data[7];
                    ptr_ff <= ptr_ff + 8'h01;
                end
                else
                begin
                    unique case (state_ff)
                        ST_DEV: state_ff <= ST_PTR;
                        ST_PTR: state_ff <= ST_WR;
                        ST_WR: ptr_ff <= ptr_ff + 8'h01;
                        ST_RD: state_ff <= ST_IDLE;
                        ST_IDLE: ;
                    endcase
                end
            end
            else if (fall)
            begin
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                if (state_ff == ST_RD)
                begin
                    shift_ff <= {shift_ff[6:0], 1'b0};
                    o_sda_oe <= ~shift_ff[6];
                end
            end
        end
    end

    // Open drain: the line is only ever pulled low
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
            o_sda <= 1'b0;
        else
            o_sda <= 1'b0;
    end

    // Soft reset pulse follows a write of the reset bit
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
            srst_ff <= 1'b0;
        else
            srst_ff <= wr_stb && ptr_ff == ADDR_RESET && shift_ff[RST_BIT];
    end

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_reg_ff <= RST_DEFAULT;
            feat_ff <= FEAT_DEFAULT;
            level_ff <= LEVEL_DEFAULT;
            enable_ff <= ENABLE_DEFAULT;
        end
        else if (srst_ff)
        begin
            rst_reg_ff <= RST_DEFAULT;
            feat_ff <= FEAT_DEFAULT;
            level_ff <= LEVEL_DEFAULT;
            enable_ff <= ENABLE_DEFAULT;
        end
        else if (wr_stb)
        begin
            unique case (ptr_ff)
                ADDR_RESET: rst_reg_ff <= shift_ff & RST_RW_MASK;
                ADDR_FEAT: feat_ff <= shift_ff;
                ADDR_LEVEL: level_ff <= shift_ff;
                ADDR_ENABLE: enable_ff <= shift_ff;
                default: ;
            endcase
        end
    end

    // Sticky fault flags; a new event wins over the read clear
    always_comb
    begin
        flag_set = 8'h00;
        flag_set[FL_TO_BIT] = to_ev;
        flag_set[FL_OTP_BIT] = otp_s;
        flag_set[FL_SHORT_BIT] = short_s;
        flag_set[FL_OVP_BIT] = ovp_s;
        flag_set[FL_INPUT_VOLTAGE_MONITOR_BIT] = input_voltage_monitor_s & enable_ff[EN_INPUT_VOLTAGE_MONITOR_BIT];
    end

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
            flags_ff <= FLAGS_DEFAULT;
        else if (rd_stb && ptr_ff == ADDR_FLAGS)
            flags_ff <= flag_set & FLAGS_MASK;
        else if (srst_ff)
            flags_ff <= (FLAGS_DEFAULT | flag_set) & FLAGS_MASK;
        else
            flags_ff <= (flags_ff | flag_set) & FLAGS_MASK;
    end

    // Flash trigger by pin or register bit in flash mode
    assign trig = enable_ff[EN_DRV_BIT] & enable_ff[EN_SEL_BIT]
        & ((enable_ff[EN_STB_BIT] & strobe_s) | enable_ff[EN_SREG_BIT]);
    assign to_ev = trig && !expired_ff && step_cnt_ff == P_FTO_STEP_CYC - 1
        && steps_ff == feat_ff[FTO_LSB +: 3];

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            step_cnt_ff <= 32'h0;
            steps_ff <= 3'h0;
            expired_ff <= 1'b0;
        end
        else if (!trig || srst_ff)
        begin
            step_cnt_ff <= 32'h0;
            steps_ff <= 3'h0;
            expired_ff <= 1'b0;
        end
        else if (!expired_ff)
        begin
            if (step_cnt_ff == P_FTO_STEP_CYC - 1)
            begin
                step_cnt_ff <= 32'h0;
                if (to_ev)
                    expired_ff <= 1'b1;
                else
                    steps_ff <= steps_ff + 3'h1;
            end
            else
                step_cnt_ff <= step_cnt_ff + 32'h1;
        end
    end

    assign flash_nxt = trig & ~expired_ff & ~to_ev & ~(enable_ff[EN_TX_BIT] & tx_s);
    assign torch_nxt = enable_ff[EN_DRV_BIT] & (~enable_ff[EN_SEL_BIT]
        | (trig & ~expired_ff & ~to_ev & enable_ff[EN_TX_BIT] & tx_s));

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_led_enable <= 1'b0;
            o_flash_on <= 1'b0;
            o_torch_on <= 1'b0;
        end
        else
        begin
            o_led_enable <= enable_ff[EN_CS_BIT] & (flash_nxt | torch_nxt);
            o_flash_on <= enable_ff[EN_CS_BIT] & flash_nxt;
            o_torch_on <= enable_ff[EN_CS_BIT] & torch_nxt;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_flash_level <= 5'h00;
            o_torch_level <= 3'h0;
            o_timeout_code <= 3'h0;
            o_batt_threshold <= 4'h0;
            o_input_voltage_monitor_enable <= 1'b0;
        end
        else
        begin
            o_flash_level <= (level_ff[FLASH_LSB +: 5] > FLASH_TOP_CODE) ? FLASH_TOP_CODE
                : level_ff[FLASH_LSB +: 5];
            o_torch_level <= level_ff[TORCH_LSB +: 3];
            o_timeout_code <= feat_ff[FTO_LSB +: 3];
            o_batt_threshold <= feat_ff[LVP_LSB + 3] ? LVP_TOP_CODE : feat_ff[LVP_LSB +: 4];
            o_input_voltage_monitor_enable <= enable_ff[EN_INPUT_VOLTAGE_MONITOR_BIT];
        end
    end

    property p_dev_nack;
        @(posedge i_mclk) disable iff (!rst_n)
        (fall && !start && !stop && state_ff == ST_DEV && bit_cnt_ff == 4'h7 && shift_ff[7:1] != DEV_ADDR)
            |=> (state_ff == ST_IDLE && !o_sda_oe);
    endproperty
    a_dev_nack: assert property (p_dev_nack) else $error("foreign address acknowledged");

    property p_srst;
        @(posedge i_mclk) disable iff (!rst_n)
        (wr_stb && ptr_ff == ADDR_RESET && shift_ff[RST_BIT])
            |-> ##2 (feat_ff == FEAT_DEFAULT && level_ff == LEVEL_DEFAULT && enable_ff == ENABLE_DEFAULT);
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset left registers changed");

    property p_to_code;
        @(posedge i_mclk) disable iff (!rst_n)
        $rose(expired_ff) |-> $past(steps_ff) == $past(feat_ff[FTO_LSB +: 3]);
    endproperty
    a_to_code: assert property (p_to_code) else $error("timeout at wrong step");

    property p_batt_low;
        @(posedge i_mclk) disable iff (!rst_n)
        (!feat_ff[LVP_LSB + 3] && !srst_ff && !wr_stb) |=> o_batt_threshold == feat_ff[LVP_LSB +: 4];
    endproperty
    a_batt_low: assert property (p_batt_low) else $error("threshold code not passed");

    property p_batt_top;
        @(posedge i_mclk) disable iff (!rst_n)
        feat_ff[LVP_LSB + 3] |=> o_batt_threshold == LVP_TOP_CODE;
    endproperty
    a_batt_top: assert property (p_batt_top) else $error("threshold not saturated");

    property p_torch;
        @(posedge i_mclk) disable iff (!rst_n)
        (!srst_ff && !wr_stb) |=> o_torch_level == $past(level_ff[TORCH_LSB +: 3]);
    endproperty
    a_torch: assert property (p_torch) else $error("torch level mismatch");

    property p_flash_top;
        @(posedge i_mclk) disable iff (!rst_n)
        (level_ff[FLASH_LSB +: 5] >= FLASH_TOP_CODE) |=> o_flash_level == FLASH_TOP_CODE;
    endproperty
    a_flash_top: assert property (p_flash_top) else $error("flash level not saturated");

    property p_cs_off;
        @(posedge i_mclk) disable iff (!rst_n)
        !enable_ff[EN_CS_BIT] |=> (!o_led_enable && !o_flash_on && !o_torch_on);
    endproperty
    a_cs_off: assert property (p_cs_off) else $error("LED driven with source disabled");

    property p_short_flag;
        @(posedge i_mclk) disable iff (!rst_n)
        short_s |=> flags_ff[FL_SHORT_BIT];
    endproperty
    a_short_flag: assert property (p_short_flag) else $error("short event lost");

    property p_ovp_clr;
        @(posedge i_mclk) disable iff (!rst_n)
        (rd_stb && ptr_ff == ADDR_FLAGS && !ovp_s) |=> !flags_ff[FL_OVP_BIT];
    endproperty
    a_ovp_clr: assert property (p_ovp_clr) else $error("overvoltage flag kept after read");

    property p_hold_off;
        @(posedge i_mclk) disable iff (!rst_n)
        to_ev |=> (!o_flash_on [*2]);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("flash past timeout");

    property p_rd_ptr;
        @(posedge i_mclk) disable iff (!rst_n)
        rd_stb && !start && !stop |=> (state_ff == ST_RD && ptr_ff == $past(ptr_ff) + 8'h01);
    endproperty
    a_rd_ptr: assert property (p_rd_ptr) else $error("read did not advance");

    c_write: cover property (@(posedge i_mclk) disable iff (!rst_n) wr_stb);
    c_read_flags: cover property (@(posedge i_mclk) disable iff (!rst_n) rd_stb && ptr_ff == ADDR_FLAGS);
    c_timeout: cover property (@(posedge i_mclk) disable iff (!rst_n) to_ev);
    c_tx_torch: cover property (@(posedge i_mclk) disable iff (!rst_n) trig && o_torch_on);
endmodule : led_output_i2c_regs

// ==== tb/led_output_host_model.sv ====
// Behavioural I2C bus master standing in for the host processor
`timescale 1ns/1ns
module led_output_host_model
    import led_output_pkg::*;
#(
    parameter int unsigned P_QTR_NS = 630
) (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_rel
);
    // Four quarters make one 2.52 us bit, so the low phase stays at 1.26 us
    // A whole number of mclk periods per quarter keeps every pin change on one clock phase
    initial
    begin
        o_scl = 1'b1;
        o_sda_rel = 1'b1;
    end

    // Also serves as repeated start, entered with the clock low
    task automatic bus_start;
        o_sda_rel = 1'b1;
        #(P_QTR_NS);
        o_scl = 1'b1;
        #(P_QTR_NS);
        o_sda_rel = 1'b0;
        #(P_QTR_NS);
        o_scl = 1'b0;
        #(P_QTR_NS);
    endtask : bus_start

    task automatic bus_stop;
        o_sda_rel = 1'b0;
        #(P_QTR_NS);
        o_scl = 1'b1;
        #(P_QTR_NS);
        o_sda_rel = 1'b1;
        #(2 * P_QTR_NS);
    endtask : bus_stop

    // Eight data bits and the acknowledge bit, most significant first
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            o_sda_rel = tx[i];
            #(P_QTR_NS);
            o_scl = 1'b1;
            #(P_QTR_NS);
            rx[i] = i_sda;
            #(P_QTR_NS);
            o_scl = 1'b0;
            #(P_QTR_NS);
        end
    endtask : xfer

    task automatic probe(input logic [6:0] addr, output logic ack);
        logic [8:0] rx;
        bus_start();
        xfer({addr, 1'b0, 1'b1}, rx);
        ack = !rx[0];
        bus_stop();
    endtask : probe

    task automatic wr_n(input logic [7:0] ptr, input int n, input logic [7:0] d [4], output logic ok);
        logic [8:0] rx;
        bus_start();
        xfer({DEV_ADDR, 1'b0, 1'b1}, rx);
        ok = !rx[0];
        xfer({ptr, 1'b1}, rx);
        ok = ok & !rx[0];
        for (int i = 0; i < n; i++)
        begin
            xfer({d[i], 1'b1}, rx);
            ok = ok & !rx[0];
        end
        bus_stop();
    endtask : wr_n

    task automatic rd_n(input logic [7:0] ptr, input int n, output logic [7:0] q [4], output logic ok);
        logic [8:0] rx;
        q = '{8'h00, 8'h00, 8'h00, 8'h00};
        bus_start();
        xfer({DEV_ADDR, 1'b0, 1'b1}, rx);
        ok = !rx[0];
        xfer({ptr, 1'b1}, rx);
        ok = ok & !rx[0];
        bus_start();
        xfer({DEV_ADDR, 1'b1, 1'b1}, rx);
        ok = ok & !rx[0];
        for (int i = 0; i < n; i++)
        begin
            xfer({8'hFF, i == n - 1}, rx);
            q[i] = rx[8:1];
        end
        bus_stop();
    endtask : rd_n
endmodule : led_output_host_model

// ==== tb/tb.sv ====
// Self-checking testbench of the flash LED control register bank
`timescale 1ns/1ns
module tb;
    localparam int unsigned STEP = 20;
    localparam int unsigned LIMIT = 100000;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic strobe = 1'b0;
    logic short_det = 1'b0;
    logic ovp_det = 1'b0;
    logic zero = 1'b0;
    logic scl;
    logic sda_rel;
    logic sda_o;
    logic sda_oe;
    logic led_en;
    logic flash_on;
    logic torch_on;
    logic input_voltage_monitor_en;
    logic [4:0] flash_lvl;
    logic [2:0] torch_lvl;
    logic [2:0] tmo_code;
    logic [3:0] batt_thr;
    logic sda_line;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;

    // Open drain with pull-up: low when either party pulls
    assign sda_line = !((sda_oe && !sda_o) || !sda_rel);

    always #5 i_mclk = ~i_mclk;

    led_output_i2c_regs #(.P_FTO_STEP_CYC(STEP)) dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(scl),
        .i_sda(sda_line), .o_sda(sda_o), .o_sda_oe(sda_oe), .i_strobe(strobe), .i_tx_mask(zero),
        .i_short_det(short_det), .i_ovp_det(ovp_det), .i_input_voltage_monitor_det(zero), .i_otp_det(zero),
        .o_led_enable(led_en), .o_flash_on(flash_on), .o_torch_on(torch_on), .o_flash_level(flash_lvl),
        .o_torch_level(torch_lvl), .o_timeout_code(tmo_code), .o_batt_threshold(batt_thr),
        .o_input_voltage_monitor_enable(input_voltage_monitor_en));

    led_output_host_model host_u (.i_sda(sda_line), .o_scl(scl), .o_sda_rel(sda_rel));

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_outs(input logic [7:0] tmo, input logic [7:0] thr, input logic [7:0] fl, input logic [7:0] tl);
        @(negedge i_mclk);
        chk({5'h0, tmo_code}, tmo);
        chk({4'h0, batt_thr}, thr);
        chk({3'h0, flash_lvl}, fl);
        chk({5'h0, torch_lvl}, tl);
    endtask : chk_outs

    task automatic test_defaults;
        logic [7:0] q [4];
        logic ok;
        host_u.rd_n(8'h08, 3, q, ok);
        chk({7'h0, ok}, 8'h01);
        chk(q[0], 8'h02);
        chk(q[1], 8'h0F);
        chk(q[2], 8'h70);
        chk_outs(8'h02, 8'h00, 8'h0F, 8'h00);
        $display("Test defaults done");
    endtask : test_defaults

    task automatic test_address;
        logic ack;
        host_u.probe(7'h64, ack);
        chk({7'h0, ack}, 8'h00);
        host_u.probe(7'h63, ack);
        chk({7'h0, ack}, 8'h01);
        $display("Test address done");
    endtask : test_address

    task automatic test_fields;
        logic ok;
        host_u.wr_n(8'h08, 2, '{8'h77, 8'hFF, 8'h00, 8'h00}, ok);
        chk({7'h0, ok}, 8'h01);
        chk_outs(8'h07, 8'h07, 8'h0F, 8'h07);
        host_u.wr_n(8'h08, 3, '{8'hF0, 8'h0E, 8'h33, 8'h00}, ok);
        chk_outs(8'h00, 8'h08, 8'h0E, 8'h00);
        $display("Test fields done");
    endtask : test_fields

    task automatic test_timeout;
        logic ok;
        @(posedge i_mclk);
        strobe <= 1'b1;
        repeat (10) @(posedge i_mclk);
        @(negedge i_mclk);
        chk({6'h0, flash_on, led_en}, 8'h03);
        repeat (40) @(negedge i_mclk);
        chk({7'h0, flash_on}, 8'h00);
        repeat (100) @(negedge i_mclk);
        chk({7'h0, flash_on}, 8'h00);
        @(posedge i_mclk);
        strobe <= 1'b0;
        repeat (10) @(posedge i_mclk);
        strobe <= 1'b1;
        repeat (10) @(negedge i_mclk);
        chk({7'h0, flash_on}, 8'h01);
        @(posedge i_mclk);
        strobe <= 1'b0;
        @(negedge i_mclk);
        host_u.wr_n(8'h0A, 1, '{8'h23, 8'h00, 8'h00, 8'h00}, ok);
        @(posedge i_mclk);
        strobe <= 1'b1;
        repeat (10) @(posedge i_mclk);
        @(negedge i_mclk);
        chk({6'h0, flash_on, led_en}, 8'h00);
        @(posedge i_mclk);
        strobe <= 1'b0;
        $display("Test timeout done");
    endtask : test_timeout

    task automatic test_torch;
        logic ok;
        @(negedge i_mclk);
        host_u.wr_n(8'h0A, 1, '{8'h91, 8'h00, 8'h00, 8'h00}, ok);
        chk({7'h0, ok}, 8'h01);
        @(negedge i_mclk);
        chk({4'h0, input_voltage_monitor_en, torch_on, flash_on, led_en}, 8'h0D);
        $display("Test torch done");
    endtask : test_torch

    task automatic test_flags;
        logic [7:0] q [4];
        logic ok;
        @(posedge i_mclk);
        short_det <= 1'b1;
        ovp_det <= 1'b1;
        repeat (6) @(posedge i_mclk);
        short_det <= 1'b0;
        ovp_det <= 1'b0;
        @(negedge i_mclk);
        host_u.rd_n(8'h0B, 2, q, ok);
        chk(q[0], 8'h0D);
        chk(q[1], 8'h00);
        host_u.rd_n(8'h0B, 1, q, ok);
        chk(q[0], 8'h00);
        $display("Test flags done");
    endtask : test_flags

    task automatic test_soft_reset;
        logic [7:0] q [4];
        logic ok;
        host_u.wr_n(8'h00, 1, '{8'h80, 8'h00, 8'h00, 8'h00}, ok);
        chk({7'h0, ok}, 8'h01);
        chk_outs(8'h02, 8'h00, 8'h0F, 8'h00);
        host_u.rd_n(8'h00, 1, q, ok);
        chk(q[0], 8'h03);
        $display("Test soft reset done");
    endtask : test_soft_reset

    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            num_errors++;
            end_sim();
        end
    end

    initial
    begin
        repeat (12) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        // Host calls start on a falling edge so bus pins never move with a sampling edge
        repeat (10) @(negedge i_mclk);
        test_defaults();
        test_address();
        test_fields();
        test_timeout();
        test_torch();
        test_flags();
        test_soft_reset();
        end_sim();
    end
endmodule : tb
